// File: verilog/oc_fault_pkg.sv
package oc_fault_pkg;

    // command code and byte layout of the response byte
    localparam logic [7:0] CMD_OC_ACTION      = 8'h47;
    localparam logic [7:0] OC_ACTION_RESET    = 8'h00;
    localparam int         RESP_MSB           = 7;
    localparam int         RESP_LSB           = 6;
    localparam int         RETRY_MSB          = 5;
    localparam int         RETRY_LSB          = 3;
    localparam int         DELAY_MSB          = 2;
    localparam int         DELAY_LSB          = 0;

    // response encodings
    localparam logic [1:0] RESP_LIMIT_FOREVER = 2'h0;
    localparam logic [1:0] RESP_UNSUPPORTED   = 2'h1;
    localparam logic [1:0] RESP_LIMIT_DELAY   = 2'h2;
    localparam logic [1:0] RESP_SHUTDOWN      = 2'h3;

    // retry encodings
    localparam logic [2:0] RETRY_NONE         = 3'h0;
    localparam logic [2:0] RETRY_FOREVER      = 3'h7;

    // timing
    localparam int         CLK_HZ             = 10_000_000;
    localparam int         TICK_MS            = 1;
    localparam int         TICK_CYCLES        = (CLK_HZ / 1000) * TICK_MS;
    localparam int         DELAY_UNIT_MS      = 16;
    localparam int         DELAY_UNIT_TICKS   = DELAY_UNIT_MS / TICK_MS;

    typedef enum logic [2:0]
    {
        ST_OFF   = 3'h0,
        ST_RUN   = 3'h1,
        ST_LIMIT = 3'h2,
        ST_DELAY = 3'h3,
        ST_LATCH = 3'h4,
        ST_RETRY = 3'h5
    } oc_state_t;

endpackage

// File: verilog/overcurrent_fault_response.sv
// Overview of operation
// [R01] an 8-bit response byte per channel picks the reaction to an overcurrent fault and is accessed as one data byte.
// [R02] an overcurrent fault sets the catch-all and overcurrent status-byte flags and the iout status-word bit.
// [R03] an overcurrent fault sets the overcurrent fault flag of the iout status register.
// [R04] an overcurrent fault drives the alert line to the host unless the alert is masked.
// [R05] the status flags are set for every response encoding, including the one that keeps running.
// [R06] a set fault flag clears only on clear-faults, an off-then-on command, restore-user-all, vendor reset or power cycle.
// [R07] response 00 keeps running indefinitely with the output current held at the limit.
// [R08] response 10 keeps limiting for the programmed delay and applies the retry policy if still limiting at the end.
// [R09] response 11 disables the output at once and then applies the retry policy.
// [R10] retry 000 never restarts and the output stays off until the run pin is cycled or power is removed.
// [R11] continuous retry restarts at the retry interval until commanded off, power is lost or another fault shuts down.
// [R12] the 3-bit delay field counts 16 ms units of operation after detection before shutdown.
// [R13] the delay field is used only with the delayed-shutdown response and is ignored otherwise.
// [R14] writing an unsupported response encoding raises a communication fault.
// [R15] the byte sits at command code 0x47, is paged, read/write and defaults to 0x00.
// [R16] the host is not to program response 01 since it is unsupported.
`timescale 1ns/1ns
module overcurrent_fault_response
#(
    parameter int TICK_CYCLES    = oc_fault_pkg::TICK_CYCLES,
    parameter int RETRY_WIDTH    = 16
)
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    // command port
    input  wire logic                   cmd_valid,
    input  wire logic                   cmd_write,
    input  wire logic                   cmd_page_hit,
    input  wire logic [7:0]             cmd_code,
    input  wire logic [7:0]             cmd_wdata,
    output logic      [7:0]             cmd_rdata,
    output logic                        cml_fault,
    // control commands, one-cycle pulses
    input  wire logic                   clear_faults_cmd,
    input  wire logic                   restore_user_all_cmd,
    input  wire logic                   vendor_soft_reset_cmd,
    // on/off control
    input  wire logic                   run_pin,
    input  wire logic                   operation_on,
    // fault inputs
    input  wire logic                   oc_detect,
    input  wire logic                   other_fault_shutdown,
    input  wire logic [RETRY_WIDTH-1:0] retry_interval_setting,
    input  wire logic                   alert_mask,
    // power stage control
    output logic                        output_enable,
    output logic                        current_limit,
    // status
    output logic                        status_none_of_above,
    output logic                        status_iout_oc,
    output logic                        status_word_iout,
    output logic                        status_iout_oc_fault,
    output logic                        alert_n
);

    logic [7:0]             action_reg;
    logic [7:0]             action_next;
    logic [7:0]             rdata_reg;
    logic [7:0]             rdata_next;
    logic                   cml_reg;
    logic                   cml_next;
    logic                   run_meta_reg;
    logic                   run_sync_reg;
    logic                   oc_meta_reg;
    logic                   oc_sync_reg;
    logic [$clog2(TICK_CYCLES+1)-1:0] div_reg;
    logic [$clog2(TICK_CYCLES+1)-1:0] div_next;
    logic                   tick;
    oc_fault_pkg::oc_state_t state_reg;
    oc_fault_pkg::oc_state_t state_next;
    logic [7:0]             delay_reg;
    logic [7:0]             delay_next;
    logic [RETRY_WIDTH-1:0] retry_reg;
    logic [RETRY_WIDTH-1:0] retry_next;
    logic                   flag_reg;
    logic                   flag_next;
    logic                   alert_n_reg;
    logic                   alert_n_next;
    logic                   en_reg;
    logic                   en_next;
    logic                   lim_reg;
    logic                   lim_next;
    logic                   commanded_on;
    logic                   fault_event;
    logic                   turn_on;
    logic                   after_shutdown;
    oc_fault_pkg::oc_state_t shut_state;
    logic [1:0]             resp;
    logic [2:0]             retry_sel;
    logic                   access_hit;

    // pin inputs pass two flip-flops
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            run_meta_reg <= 1'b0;
            run_sync_reg <= 1'b0;
            oc_meta_reg  <= 1'b0;
            oc_sync_reg  <= 1'b0;
        end
        else
        begin
            run_meta_reg <= run_pin;
            run_sync_reg <= run_meta_reg;
            oc_meta_reg  <= oc_detect;
            oc_sync_reg  <= oc_meta_reg;
        end
    end

    assign resp         = action_reg[oc_fault_pkg::RESP_MSB:oc_fault_pkg::RESP_LSB];
    assign retry_sel    = action_reg[oc_fault_pkg::RETRY_MSB:oc_fault_pkg::RETRY_LSB];
    assign access_hit   = cmd_valid && cmd_page_hit && (cmd_code == oc_fault_pkg::CMD_OC_ACTION);
    assign commanded_on = run_sync_reg && operation_on;
    assign tick         = (div_reg == '0);

    // response byte access and communication fault
    always_comb
    begin
        action_next = action_reg;
        rdata_next  = rdata_reg;
        cml_next    = 1'b0;
        if (access_hit && cmd_write)
        begin
            if (cmd_wdata[oc_fault_pkg::RESP_MSB:oc_fault_pkg::RESP_LSB] == oc_fault_pkg::RESP_UNSUPPORTED)
            begin
                cml_next = 1'b1; // [R14]
            end
            else
            begin
                action_next = cmd_wdata; // [R01] [R15]
            end
        end
        else if (access_hit)
        begin
            rdata_next = action_reg; // [R01]
        end
        if (restore_user_all_cmd || vendor_soft_reset_cmd)
        begin
            action_next = oc_fault_pkg::OC_ACTION_RESET; // [R15]
        end
    end

    // millisecond tick divider
    always_comb
    begin
        div_next = tick ? ($bits(div_reg))'(TICK_CYCLES - 1) : div_reg - 1'b1;
    end

    // state after an output shutdown, chosen by the retry field
    always_comb
    begin
        if (retry_sel == oc_fault_pkg::RETRY_FOREVER)
        begin
            shut_state = oc_fault_pkg::ST_RETRY; // [R11]
        end
        else
        begin
            shut_state = oc_fault_pkg::ST_LATCH; // [R10]
        end
    end

    // fault response sequencer
    always_comb
    begin
        state_next     = state_reg;
        delay_next     = delay_reg;
        retry_next     = retry_reg;
        fault_event    = 1'b0;
        turn_on        = 1'b0;
        after_shutdown = 1'b0;
        unique case (state_reg)
            oc_fault_pkg::ST_OFF:
            begin
                if (commanded_on)
                begin
                    state_next = oc_fault_pkg::ST_RUN;
                    turn_on    = 1'b1;
                end
            end
            oc_fault_pkg::ST_RUN:
            begin
                if (oc_sync_reg)
                begin
                    fault_event = 1'b1; // [R05]
                    unique case (resp)
                        oc_fault_pkg::RESP_LIMIT_DELAY:
                        begin
                            state_next = oc_fault_pkg::ST_DELAY; // [R08]
                            delay_next = 8'(action_reg[oc_fault_pkg::DELAY_MSB:oc_fault_pkg::DELAY_LSB]
                                         * oc_fault_pkg::DELAY_UNIT_TICKS); // [R12] [R13]
                        end
                        oc_fault_pkg::RESP_SHUTDOWN:
                        begin
                            after_shutdown = 1'b1; // [R09]
                        end
                        default:
                        begin
                            state_next = oc_fault_pkg::ST_LIMIT; // [R07]
                        end
                    endcase
                end
            end
            oc_fault_pkg::ST_LIMIT:
            begin
                if (!oc_sync_reg)
                begin
                    state_next = oc_fault_pkg::ST_RUN; // [R07]
                end
            end
            oc_fault_pkg::ST_DELAY:
            begin
                if (!oc_sync_reg)
                begin
                    state_next = oc_fault_pkg::ST_RUN;
                end
                else if (delay_reg == 8'h00)
                begin
                    after_shutdown = 1'b1; // [R08]
                end
                else if (tick)
                begin
                    delay_next = delay_reg - 8'h01; // [R12]
                end
            end
            oc_fault_pkg::ST_LATCH:
            begin
                state_next = oc_fault_pkg::ST_LATCH; // [R10]
            end
            oc_fault_pkg::ST_RETRY:
            begin
                if (other_fault_shutdown)
                begin
                    state_next = oc_fault_pkg::ST_LATCH; // [R11]
                end
                else if (retry_reg == '0)
                begin
                    state_next = oc_fault_pkg::ST_RUN; // [R11]
                end
                else if (tick)
                begin
                    retry_next = retry_reg - 1'b1;
                end
            end
            default:
            begin
                state_next = oc_fault_pkg::ST_OFF;
            end
        endcase
        if (after_shutdown)
        begin
            state_next = shut_state; // [R08] [R09]
            retry_next = retry_interval_setting; // [R11]
        end
        if (!commanded_on)
        begin
            state_next = oc_fault_pkg::ST_OFF; // [R10] [R11]
        end
    end

    // status flags, alert and power stage outputs
    always_comb
    begin
        flag_next = flag_reg;
        if (clear_faults_cmd || restore_user_all_cmd || vendor_soft_reset_cmd || turn_on)
        begin
            flag_next = 1'b0; // [R06]
        end
        if (fault_event)
        begin
            flag_next = 1'b1; // [R02] [R03] [R05]
        end
        alert_n_next = !(flag_next && !alert_mask); // [R04]
        en_next      = (state_next == oc_fault_pkg::ST_RUN) || (state_next == oc_fault_pkg::ST_LIMIT)
                       || (state_next == oc_fault_pkg::ST_DELAY); // [R09]
        lim_next     = (state_next == oc_fault_pkg::ST_LIMIT) || (state_next == oc_fault_pkg::ST_DELAY); // [R07] [R08]
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            action_reg  <= oc_fault_pkg::OC_ACTION_RESET;
            rdata_reg   <= 8'h00;
            cml_reg     <= 1'b0;
            div_reg     <= '0;
            state_reg   <= oc_fault_pkg::ST_OFF;
            delay_reg   <= 8'h00;
            retry_reg   <= '0;
            flag_reg    <= 1'b0;
            alert_n_reg <= 1'b1;
            en_reg      <= 1'b0;
            lim_reg     <= 1'b0;
        end
        else
        begin
            action_reg  <= action_next;
            rdata_reg   <= rdata_next;
            cml_reg     <= cml_next;
            div_reg     <= div_next;
            state_reg   <= state_next;
            delay_reg   <= delay_next;
            retry_reg   <= retry_next;
            flag_reg    <= flag_next;
            alert_n_reg <= alert_n_next;
            en_reg      <= en_next;
            lim_reg     <= lim_next;
        end
    end

    assign cmd_rdata            = rdata_reg;
    assign cml_fault            = cml_reg;
    assign output_enable        = en_reg;
    assign current_limit        = lim_reg;
    assign status_none_of_above = flag_reg;
    assign status_iout_oc       = flag_reg;
    assign status_word_iout     = flag_reg;
    assign status_iout_oc_fault = flag_reg;
    assign alert_n              = alert_n_reg;

endmodule // overcurrent_fault_response

// File: dv/overcurrent_fault_response_assertions.sv
`timescale 1ns/1ns
module overcurrent_fault_response_assertions
(
    // clock and reset
    input wire logic       mclk,
    input wire logic       arst_n,
    // command port
    input wire logic       cmd_valid,
    input wire logic       cmd_write,
    input wire logic       cmd_page_hit,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_rdata,
    input wire logic       cml_fault,
    // controls
    input wire logic       clear_faults_cmd,
    input wire logic       restore_user_all_cmd,
    input wire logic       vendor_soft_reset_cmd,
    input wire logic       alert_mask,
    // outputs
    input wire logic       output_enable,
    input wire logic       current_limit,
    input wire logic       status_none_of_above,
    input wire logic       status_iout_oc,
    input wire logic       status_word_iout,
    input wire logic       status_iout_oc_fault,
    input wire logic       alert_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic [7:0] act_reg;
    logic [7:0] act_next;
    logic       hit;
    assign hit = cmd_valid && cmd_page_hit && cmd_code == 8'h47;
    // shadow of the stored response byte
    always_comb
    begin
        act_next = act_reg;
        if (restore_user_all_cmd || vendor_soft_reset_cmd)
            act_next = 8'h00;
        else if (hit && cmd_write && cmd_wdata[7:6] != 2'h1)
            act_next = cmd_wdata;
    end
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            act_reg <= 8'h00;
        else
            act_reg <= act_next;
    end
    status_group_a: assert property (status_none_of_above == status_iout_oc_fault && status_iout_oc ==
        status_iout_oc_fault && status_word_iout == status_iout_oc_fault) else $error("status bits disagree");
    alert_level_a: assert property ((status_iout_oc_fault && !alert_mask) [*2] |-> !alert_n)
        else $error("alert not asserted");
    refuse_write_a: assert property (hit && cmd_write && cmd_wdata[7:6] == 2'h1 |=> cml_fault)
        else $error("refused write gave no cml pulse");
    cml_cause_a: assert property (cml_fault |-> $past(hit && cmd_write && cmd_wdata[7:6] == 2'h1))
        else $error("cml pulse without cause");
    read_back_a: assert property (hit && !cmd_write |=> cmd_rdata == $past(act_reg))
        else $error("read data wrong");
    rdata_hold_a: assert property (!(hit && !cmd_write) |=> $stable(cmd_rdata))
        else $error("read data moved");
    flag_sticky_a: assert property ($fell(status_iout_oc_fault) |-> $past(clear_faults_cmd ||
        restore_user_all_cmd || vendor_soft_reset_cmd) || !$past(output_enable)) else $error("flag cleared early");
    limit_forever_a: assert property ($rose(status_iout_oc_fault) && act_reg[7:6] == 2'h0
        |-> ##[0:1] (current_limit && output_enable)) else $error("no limiting on response 00");
    limit_delay_a: assert property ($rose(status_iout_oc_fault) && act_reg[7:6] == 2'h2
        |-> ##[0:1] (current_limit && output_enable)) else $error("no limiting on response 10");
    shut_now_a: assert property ($rose(status_iout_oc_fault) && act_reg[7:6] == 2'h3
        |-> ##[0:1] !output_enable) else $error("no shutdown on response 11");
endmodule // overcurrent_fault_response_assertions
bind overcurrent_fault_response overcurrent_fault_response_assertions chk_i (.mclk, .arst_n, .cmd_valid,
    .cmd_write, .cmd_page_hit, .cmd_code, .cmd_wdata, .cmd_rdata, .cml_fault, .clear_faults_cmd,
    .restore_user_all_cmd, .vendor_soft_reset_cmd, .alert_mask, .output_enable, .current_limit,
    .status_none_of_above, .status_iout_oc, .status_word_iout, .status_iout_oc_fault, .alert_n);

// File: dv/oc_host_model.sv
`timescale 1ns/1ns
module oc_host_model
(
    // clock
    input  wire logic       mclk,
    // command port
    output logic            cmd_valid,
    output logic            cmd_write,
    output logic            cmd_page_hit,
    output logic      [7:0] cmd_code,
    output logic      [7:0] cmd_wdata,
    input  wire logic [7:0] cmd_rdata
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_page_hit = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 8'h00;
    end
    // one byte access, response 01 only when a refusal is wanted
    task automatic xfer(input logic w, input logic pg, input logic [7:0] c, input logic [7:0] d);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_page_hit = pg;
        cmd_code = c;
        cmd_wdata = d;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_code = ~c;
        cmd_wdata = ~d;
    endtask
    task automatic read(output logic [7:0] d);
        xfer(1'b0, 1'b1, 8'h47, 8'h00);
        @(negedge mclk);
        d = cmd_rdata;
    endtask
endmodule // oc_host_model

// File: dv/overcurrent_fault_response_tb.sv
`timescale 1ns/1ns
module overcurrent_fault_response_tb;
    logic mclk = 0, arst_n = 0, clear_faults_cmd = 0, restore_user_all_cmd = 0, vendor_soft_reset_cmd = 0;
    logic run_pin = 0, operation_on = 0, oc_detect = 0, other_fault_shutdown = 0, alert_mask = 0;
    logic [15:0] retry_interval_setting = 16'h0005;
    logic cmd_valid, cmd_write, cmd_page_hit, cml_fault, output_enable, current_limit, alert_n;
    logic status_none_of_above, status_iout_oc, status_word_iout, status_iout_oc_fault;
    logic [7:0] cmd_code, cmd_wdata, cmd_rdata, rd;
    int err_count = 0, checks = 0, cml_seen = 0;
    always #50 mclk = ~mclk;
    always @(posedge mclk) if (cml_fault === 1'b1) cml_seen++;
    overcurrent_fault_response #(.TICK_CYCLES(4)) overcurrent_fault_response_i (.mclk, .arst_n, .cmd_valid,
        .cmd_write, .cmd_page_hit, .cmd_code, .cmd_wdata, .cmd_rdata, .cml_fault, .clear_faults_cmd,
        .restore_user_all_cmd, .vendor_soft_reset_cmd, .run_pin, .operation_on, .oc_detect, .other_fault_shutdown,
        .retry_interval_setting, .alert_mask, .output_enable, .current_limit, .status_none_of_above,
        .status_iout_oc, .status_word_iout, .status_iout_oc_fault, .alert_n);
    oc_host_model oc_host_model_i (.mclk, .cmd_valid, .cmd_write, .cmd_page_hit, .cmd_code, .cmd_wdata, .cmd_rdata);
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // bounded wait for output_enable (k=0) or the fault flag (k=1)
    task automatic wait_for(input int k, input logic v);
        int i;
        for (i = 0; i < 400 && (k == 0 ? output_enable : status_iout_oc_fault) !== v; i++)
            @(negedge mclk);
        if (i == 400)
        begin
            chk("wait bound", 8'h01, 8'h00);
            end_of_test();
        end
    endtask
    task automatic stat(input logic [7:0] exp);
        chk("status", {status_none_of_above, status_iout_oc, status_word_iout, status_iout_oc_fault,
            alert_n, current_limit, output_enable, 1'b0}, exp);
    endtask
    task automatic fault(input logic [7:0] act);
        oc_host_model_i.xfer(1'b1, 1'b1, 8'h47, act);
        oc_detect = 1'b1;
        wait_for(1, 1'b1);
        cyc(2);
    endtask
    initial
    begin
        cyc(6);
        arst_n = 1'b1;
        cyc(1);
        oc_host_model_i.read(rd);
        chk("default", rd, 8'h00);
        stat(8'h08);
        oc_host_model_i.xfer(1'b1, 1'b1, 8'h47, 8'h40);
        oc_host_model_i.xfer(1'b1, 1'b0, 8'h47, 8'hC0);
        oc_host_model_i.xfer(1'b1, 1'b1, 8'h48, 8'hC0);
        oc_host_model_i.read(rd);
        chk("refused", rd, 8'h00);
        chk("cml", cml_seen[7:0], 8'h01);
        $display("test access done");
        run_pin = 1'b1;
        operation_on = 1'b1;
        wait_for(0, 1'b1);
        fault(8'h01);
        stat(8'hF6);
        cyc(200);
        stat(8'hF6);
        alert_mask = 1'b1;
        cyc(2);
        chk("masked", {7'h00, alert_n}, 8'h01);
        alert_mask = 1'b0;
        oc_detect = 1'b0;
        cyc(10);
        chk("sticky", {7'h00, status_iout_oc_fault}, 8'h01);
        clear_faults_cmd = 1'b1;
        cyc(1);
        clear_faults_cmd = 1'b0;
        cyc(2);
        stat(8'h0A);
        $display("test limit forever done");
        fault(8'h81);
        cyc(40);
        chk("in delay", {6'h00, current_limit, output_enable}, 8'h03);
        cyc(50);
        chk("after delay", {7'h00, output_enable}, 8'h00);
        oc_detect = 1'b0;
        cyc(100);
        chk("no restart", {7'h00, output_enable}, 8'h00);
        run_pin = 1'b0;
        cyc(6);
        run_pin = 1'b1;
        wait_for(0, 1'b1);
        chk("run cycled", {7'h00, status_iout_oc_fault}, 8'h00);
        $display("test delayed shutdown done");
        fault(8'hF8);
        chk("shut now", {7'h00, output_enable}, 8'h00);
        cyc(8);
        chk("retry wait", {7'h00, output_enable}, 8'h00);
        oc_detect = 1'b0;
        wait_for(0, 1'b1);
        oc_detect = 1'b1;
        cyc(3);
        other_fault_shutdown = 1'b1;
        cyc(5);
        other_fault_shutdown = 1'b0;
        oc_detect = 1'b0;
        cyc(150);
        chk("stopped", {7'h00, output_enable}, 8'h00);
        $display("test retry done");
        restore_user_all_cmd = 1'b1;
        cyc(1);
        restore_user_all_cmd = 1'b0;
        oc_host_model_i.read(rd);
        chk("restored", {rd[7:1], status_iout_oc_fault}, 8'h00);
        oc_host_model_i.xfer(1'b1, 1'b1, 8'h47, 8'hC0);
        vendor_soft_reset_cmd = 1'b1;
        cyc(1);
        vendor_soft_reset_cmd = 1'b0;
        oc_host_model_i.read(rd);
        chk("vendor reset", rd, 8'h00);
        $display("test restore done");
        end_of_test();
    end
endmodule // overcurrent_fault_response_tb
